// File: pkg/dcic_regs.svh
// Register offsets, bit positions, reset values and timing of the controller
`ifndef DCIC_REGS_SVH
`define DCIC_REGS_SVH

// ----------------------------------------------------------------------
// Software-facing registers of the controller (4-bit word address)
// ----------------------------------------------------------------------
`define DCIC_SW_CFG 4'h0
`define DCIC_SW_CMD 4'h1
`define DCIC_SW_STAT 4'h2
`define DCIC_SW_TRIM 4'h3

// ----------------------------------------------------------------------
// Device register addresses on the device access port
// ----------------------------------------------------------------------
`define DCIC_DEV_PIN4 8'h00
`define DCIC_DEV_SRC 8'h01
`define DCIC_DEV_DET1 8'h02
`define DCIC_DEV_DET2 8'h03
`define DCIC_DEV_CTL1 8'h04
`define DCIC_DEV_CTL2 8'h05
`define DCIC_DEV_TYPE 8'h06
`define DCIC_DEV_EDGE 8'h07
`define DCIC_DEV_CLK1 8'h08
`define DCIC_DEV_TRIM 8'h09
`define DCIC_DEV_TRIMA 8'h0a
`define DCIC_DEV_TRIMB 8'h0b
`define DCIC_DEV_BGR 8'h0c

// ----------------------------------------------------------------------
// Device bit positions
// ----------------------------------------------------------------------
`define DCIC_PINSEL_BIT 4
`define DCIC_REFSEL_BIT 0
`define DCIC_SRC1_BIT 5
`define DCIC_SRC2_BIT 6
`define DCIC_VD0_EN_BIT 5
`define DCIC_EN1_BIT 6
`define DCIC_EN2_BIT 7
`define DCIC_RES2_BIT 3
`define DCIC_CTL_IEN_BIT 0
`define DCIC_CTL_FDIS_BIT 1
`define DCIC_CTL_DFLAG_BIT 2
`define DCIC_CTL_RES_BIT 3
`define DCIC_CTL_F0_BIT 4
`define DCIC_CTL_F1_BIT 5
`define DCIC_CTL_DIR_BIT 7
`define DCIC_TYPE1_BIT 1
`define DCIC_TYPE2_BIT 2
`define DCIC_EDGE1_BIT 1
`define DCIC_EDGE2_BIT 2
`define DCIC_OSC_STOP_BIT 4
`define DCIC_BG_DIS_BIT 0

// ----------------------------------------------------------------------
// Reset values of the shadow copies and the controller registers
// ----------------------------------------------------------------------
`define DCIC_SHADOW_RST 8'h00
`define DCIC_CTL_RST 8'h00
`define DCIC_CFG_RST 7'h00

// ----------------------------------------------------------------------
// Timing: times in their own unit, cycle counts derived in the module
// ----------------------------------------------------------------------
`define DCIC_CLK_KHZ 125000
`define DCIC_TD_EA_US 100
`define DCIC_LOCO_KHZ 125
`define DCIC_SAMPLE_DIV 2
`define DCIC_FILT_SAMPLES 2

`endif

// File: pkg/dcic_pkg.sv
// Types shared by the comparator controller
package dcic_pkg;

	// ------------------------------------------------------------------
	// Sequencer states
	// ------------------------------------------------------------------
	typedef enum logic [18:0] {
		ST_IDLE = 19'h00001,
		ST_PIN = 19'h00002,
		ST_SRC = 19'h00004,
		ST_EN = 19'h00008,
		ST_WAIT_EA = 19'h00010,
		ST_TYPE = 19'h00020,
		ST_FILT = 19'h00040,
		ST_EDGE = 19'h00080,
		ST_DIR = 19'h00100,
		ST_CLR = 19'h00200,
		ST_OSC = 19'h00400,
		ST_WAIT_F = 19'h00800,
		ST_IEN = 19'h01000,
		ST_RD_ISS = 19'h02000,
		ST_RD_WAIT = 19'h04000,
		ST_RD_CAP = 19'h08000,
		ST_TRIM_WR = 19'h10000,
		ST_BG_EN = 19'h20000,
		ST_BG_OFF = 19'h40000
	} dcic_state_e;

	// ------------------------------------------------------------------
	// Software commands
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		OP_NONE = 3'h0,
		OP_ARM = 3'h1,
		OP_MON = 3'h2,
		OP_STAT = 3'h3,
		OP_TRIM_A = 3'h4,
		OP_TRIM_B = 3'h5,
		OP_BG_OFF = 3'h6,
		OP_BG_ON = 3'h7
	} dcic_op_e;

	// Device access port, one transfer per cycle
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} dcic_bus_s;

	// Arming configuration written by software
	typedef struct packed {
		logic irq_mask;
		logic edge_dir;
		logic edge_mode;
		logic [1:0] fsel;
		logic use_filt;
		logic ref_ext;
	} dcic_cfg_s;

endpackage : dcic_pkg

// File: core/dcic_ctrl.sv
// Host controller that sets up and monitors a dual comparator device
`timescale 1ns/100ps
`include "dcic_regs.svh"


module dcic_ctrl #(
	parameter int TD_EA_CYC = `DCIC_TD_EA_US * `DCIC_CLK_KHZ / 1000,
	parameter int LOCO_CYC =
		(`DCIC_CLK_KHZ + `DCIC_LOCO_KHZ - 1) / `DCIC_LOCO_KHZ,
	parameter int CNT_W = 20
) (
	input wire logic I_REF_CLK,
	input wire logic I_RST,
	input wire logic [3:0] I_SW_ADDR,
	input wire logic [7:0] I_SW_WDATA,
	input wire logic I_SW_WR,
	input wire logic I_SW_RD,
	output logic [7:0] O_SW_RDATA,
	output dcic_pkg::dcic_bus_s O_DEV_BUS,
	input wire logic [7:0] I_DEV_RDATA
);

	// ------------------------------------------------------------------
	// Parameter checks and derived counts
	// ------------------------------------------------------------------
	localparam int FWAIT_BASE =
		`DCIC_FILT_SAMPLES * `DCIC_SAMPLE_DIV * LOCO_CYC;
	// Longest filter wait uses the largest divider, eight
	localparam int FWAIT_MAX = FWAIT_BASE * 8;

	// Counter must hold both waits, else a wait would wrap short
	if (TD_EA_CYC < 1 || LOCO_CYC < 1 || TD_EA_CYC >= (1 << CNT_W) ||
		FWAIT_MAX >= (1 << CNT_W)) begin : g_bad_params
		$error("dcic_ctrl: wait counts do not fit the counter");
	end

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	dcic_pkg::dcic_state_e state_ff;
	dcic_pkg::dcic_state_e nxt_state;
	dcic_pkg::dcic_op_e op_ff;
	dcic_pkg::dcic_cfg_s cfg_ff;
	dcic_pkg::dcic_bus_s bus_ff;
	dcic_pkg::dcic_bus_s nxt_bus;
	logic ch_ff;
	logic rd_sec_ff;
	logic err_ff;
	logic done_ff;
	logic [1:0] res_ff;
	logic [1:0] dflag_ff;
	logic [7:0] trim_cap_ff;
	logic [7:0] sw_rdata_ff;
	logic [CNT_W-1:0] cnt_ff;
	logic [CNT_W-1:0] filt_cyc;
	logic [7:0] sh_pin_ff;
	logic [7:0] sh_src_ff;
	logic [7:0] sh_en_ff;
	logic [7:0] sh_type_ff;
	logic [7:0] sh_edge_ff;
	logic [7:0] sh_clk_ff;
	logic [7:0] sh_bg_ff;
	logic [7:0] sh_ctl_ff [2];
	logic [7:0] ctl_base;
	logic busy;
	logic cmd_wr;
	logic cmd_go;

	// ------------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------------
	// Returns a byte with one bit replaced
	function automatic logic [7:0] setb(input logic [7:0] v,
		input int pos, input logic b);
		logic [7:0] r;
		r = v;
		r[pos] = b;
		return r;
	endfunction : setb

	// Bit position that depends on the channel
	function automatic int chbit(input logic ch, input int p1,
		input int p2);
		return ch ? p2 : p1;
	endfunction : chbit

	// Address of the per-channel control register
	function automatic logic [7:0] ctl_addr(input logic ch);
		return ch ? `DCIC_DEV_CTL2 : `DCIC_DEV_CTL1;
	endfunction : ctl_addr

	// Address for the read phase of the current command
	function automatic logic [7:0] rd_addr(input dcic_pkg::dcic_op_e op,
		input logic ch, input logic sec);
		logic [7:0] a;
		a = sec ? `DCIC_DEV_DET1 : ctl_addr(ch);
		if (op == dcic_pkg::OP_TRIM_A) begin
			a = `DCIC_DEV_TRIMA;
		end else if (op == dcic_pkg::OP_TRIM_B) begin
			a = `DCIC_DEV_TRIMB;
		end
		return a;
	endfunction : rd_addr

	// ------------------------------------------------------------------
	// Command decode
	// ------------------------------------------------------------------
	// Commands are taken only in idle; one arriving while busy is refused
	assign busy = (state_ff != dcic_pkg::ST_IDLE);
	assign cmd_wr = I_SW_WR && (I_SW_ADDR == `DCIC_SW_CMD);
	assign cmd_go = cmd_wr && !busy;
	// Flag stays written as one so other writes never clear it
	assign ctl_base = setb(sh_ctl_ff[ch_ff], `DCIC_CTL_DFLAG_BIT, 1'b1);
	// Two sample clocks of 2 x divided oscillator period each
	assign filt_cyc = CNT_W'(FWAIT_BASE) << cfg_ff.fsel;

	// ------------------------------------------------------------------
	// Sequencer next state and device transfer
	// ------------------------------------------------------------------
	// Write and read-issue steps issue one transfer each; the bus register adds one cycle
	always_comb begin
		nxt_state = state_ff;
		nxt_bus = '0;
		case (state_ff)
			dcic_pkg::ST_IDLE: begin
				if (cmd_go) begin
					case (dcic_pkg::dcic_op_e'(I_SW_WDATA[2:0]))
						dcic_pkg::OP_ARM: nxt_state = dcic_pkg::ST_PIN;
						dcic_pkg::OP_MON: nxt_state = dcic_pkg::ST_PIN;
						dcic_pkg::OP_STAT: nxt_state = dcic_pkg::ST_RD_ISS;
						dcic_pkg::OP_TRIM_A: nxt_state = dcic_pkg::ST_RD_ISS;
						dcic_pkg::OP_TRIM_B: nxt_state = dcic_pkg::ST_RD_ISS;
						dcic_pkg::OP_BG_OFF: nxt_state = dcic_pkg::ST_BG_EN;
						dcic_pkg::OP_BG_ON: nxt_state = dcic_pkg::ST_BG_OFF;
						default: nxt_state = dcic_pkg::ST_IDLE;
					endcase
				end
			end
			dcic_pkg::ST_PIN: begin
				nxt_bus.wr = 1'b1;
				nxt_bus.addr = `DCIC_DEV_PIN4;
				nxt_bus.wdata = setb(sh_pin_ff, `DCIC_PINSEL_BIT, 1'b1);
				nxt_state = dcic_pkg::ST_SRC;
			end
			dcic_pkg::ST_SRC: begin
				nxt_bus.wr = 1'b1;
				nxt_bus.addr = `DCIC_DEV_SRC;
				nxt_bus.wdata = setb(setb(sh_src_ff,
					chbit(ch_ff, `DCIC_SRC1_BIT, `DCIC_SRC2_BIT), 1'b1),
					`DCIC_REFSEL_BIT, cfg_ff.ref_ext);
				nxt_state = dcic_pkg::ST_EN;
			end
			dcic_pkg::ST_EN: begin
				nxt_bus.wr = 1'b1;
				nxt_bus.addr = `DCIC_DEV_DET2;
				nxt_bus.wdata = setb(sh_en_ff,
					chbit(ch_ff, `DCIC_EN1_BIT, `DCIC_EN2_BIT), 1'b1);
				nxt_state = dcic_pkg::ST_WAIT_EA;
			end
			dcic_pkg::ST_WAIT_EA: begin
				// Results are not trusted until the comparator is active
				if (cnt_ff == '0) begin
					nxt_state = (op_ff == dcic_pkg::OP_ARM) ?
						dcic_pkg::ST_TYPE : dcic_pkg::ST_RD_ISS;
				end
			end
			dcic_pkg::ST_TYPE: begin
				nxt_bus.wr = 1'b1;
				nxt_bus.addr = `DCIC_DEV_TYPE;
				nxt_bus.wdata = setb(sh_type_ff,
					chbit(ch_ff, `DCIC_TYPE1_BIT, `DCIC_TYPE2_BIT),
					cfg_ff.irq_mask);
				nxt_state = dcic_pkg::ST_FILT;
			end
			dcic_pkg::ST_FILT: begin
				// Interrupt is still off, so clock and filter go together
				nxt_bus.wr = 1'b1;
				nxt_bus.addr = ctl_addr(ch_ff);
				nxt_bus.wdata = ctl_base;
				nxt_bus.wdata[`DCIC_CTL_IEN_BIT] = 1'b0;
				nxt_bus.wdata[`DCIC_CTL_F0_BIT] = cfg_ff.fsel[0];
				nxt_bus.wdata[`DCIC_CTL_F1_BIT] = cfg_ff.fsel[1];
				nxt_bus.wdata[`DCIC_CTL_FDIS_BIT] = !cfg_ff.use_filt;
				nxt_state = dcic_pkg::ST_EDGE;
			end
			dcic_pkg::ST_EDGE: begin
				nxt_bus.wr = 1'b1;
				nxt_bus.addr = `DCIC_DEV_EDGE;
				nxt_bus.wdata = setb(sh_edge_ff,
					chbit(ch_ff, `DCIC_EDGE1_BIT, `DCIC_EDGE2_BIT),
					cfg_ff.edge_mode);
				nxt_state = dcic_pkg::ST_DIR;
			end
			dcic_pkg::ST_DIR: begin
				// Direction is written after the mode it depends on
				nxt_bus.wr = 1'b1;
				nxt_bus.addr = ctl_addr(ch_ff);
				nxt_bus.wdata = setb(ctl_base, `DCIC_CTL_DIR_BIT,
					cfg_ff.edge_dir);
				nxt_state = dcic_pkg::ST_CLR;
			end
			dcic_pkg::ST_CLR: begin
				// Earlier rewrites may have set the flag spuriously
				nxt_bus.wr = 1'b1;
				nxt_bus.addr = ctl_addr(ch_ff);
				nxt_bus.wdata = setb(ctl_base, `DCIC_CTL_DFLAG_BIT, 1'b0);
				nxt_state = dcic_pkg::ST_OSC;
			end
			dcic_pkg::ST_OSC: begin
				nxt_bus.wr = 1'b1;
				nxt_bus.addr = `DCIC_DEV_CLK1;
				nxt_bus.wdata = setb(sh_clk_ff, `DCIC_OSC_STOP_BIT, 1'b0);
				nxt_state = dcic_pkg::ST_WAIT_F;
			end
			dcic_pkg::ST_WAIT_F: begin
				if (cnt_ff == '0) begin
					nxt_state = dcic_pkg::ST_IEN;
				end
			end
			dcic_pkg::ST_IEN: begin
				nxt_bus.wr = 1'b1;
				nxt_bus.addr = ctl_addr(ch_ff);
				nxt_bus.wdata = setb(ctl_base, `DCIC_CTL_IEN_BIT, 1'b1);
				nxt_state = dcic_pkg::ST_IDLE;
			end
			dcic_pkg::ST_RD_ISS: begin
				nxt_bus.rd = 1'b1;
				nxt_bus.addr = rd_addr(op_ff, ch_ff, rd_sec_ff);
				nxt_state = dcic_pkg::ST_RD_WAIT;
			end
			dcic_pkg::ST_RD_WAIT: begin
				nxt_state = dcic_pkg::ST_RD_CAP;
			end
			dcic_pkg::ST_RD_CAP: begin
				nxt_state = dcic_pkg::ST_IDLE;
				if (op_ff == dcic_pkg::OP_TRIM_A ||
					op_ff == dcic_pkg::OP_TRIM_B) begin
					nxt_state = dcic_pkg::ST_TRIM_WR;
				end else if (ch_ff && !rd_sec_ff) begin
					nxt_state = dcic_pkg::ST_RD_ISS;
				end
			end
			dcic_pkg::ST_TRIM_WR: begin
				nxt_bus.wr = 1'b1;
				nxt_bus.addr = `DCIC_DEV_TRIM;
				nxt_bus.wdata = trim_cap_ff;
				nxt_state = dcic_pkg::ST_IDLE;
			end
			dcic_pkg::ST_BG_EN: begin
				// Stop detector 0 always; comparators only on internal ref
				nxt_bus.wr = 1'b1;
				nxt_bus.addr = `DCIC_DEV_DET2;
				nxt_bus.wdata = setb(sh_en_ff, `DCIC_VD0_EN_BIT, 1'b0);
				if (!cfg_ff.ref_ext) begin
					nxt_bus.wdata[`DCIC_EN1_BIT] = 1'b0;
					nxt_bus.wdata[`DCIC_EN2_BIT] = 1'b0;
				end
				nxt_state = dcic_pkg::ST_BG_OFF;
			end
			dcic_pkg::ST_BG_OFF: begin
				nxt_bus.wr = 1'b1;
				nxt_bus.addr = `DCIC_DEV_BGR;
				nxt_bus.wdata = setb(sh_bg_ff, `DCIC_BG_DIS_BIT,
					op_ff == dcic_pkg::OP_BG_OFF);
				nxt_state = dcic_pkg::ST_IDLE;
			end
			default: nxt_state = dcic_pkg::ST_IDLE;
		endcase
	end

	// ------------------------------------------------------------------
	// State and device port registers
	// ------------------------------------------------------------------
	always_ff @(posedge I_REF_CLK or posedge I_RST) begin
		if (I_RST) begin
			state_ff <= dcic_pkg::ST_IDLE;
			bus_ff <= '0;
		end else begin
			state_ff <= nxt_state;
			bus_ff <= nxt_bus;
		end
	end

	// Command latch: channel and operation held for the whole sequence
	always_ff @(posedge I_REF_CLK or posedge I_RST) begin
		if (I_RST) begin
			op_ff <= dcic_pkg::OP_NONE;
			ch_ff <= 1'b0;
		end else if (cmd_go) begin
			op_ff <= dcic_pkg::dcic_op_e'(I_SW_WDATA[2:0]);
			ch_ff <= I_SW_WDATA[3];
		end
	end

	// Configuration may change only in idle so a sequence stays coherent
	always_ff @(posedge I_REF_CLK or posedge I_RST) begin
		if (I_RST) begin
			cfg_ff <= `DCIC_CFG_RST;
		end else if (I_SW_WR && I_SW_ADDR == `DCIC_SW_CFG && !busy) begin
			cfg_ff <= dcic_pkg::dcic_cfg_s'(I_SW_WDATA[6:0]);
		end
	end

	// ------------------------------------------------------------------
	// Wait timer
	// ------------------------------------------------------------------
	// Loaded on the issuing step, so the wait covers the port latency
	always_ff @(posedge I_REF_CLK or posedge I_RST) begin
		if (I_RST) begin
			cnt_ff <= '0;
		end else if (state_ff == dcic_pkg::ST_EN) begin
			cnt_ff <= CNT_W'(TD_EA_CYC);
		end else if (state_ff == dcic_pkg::ST_OSC) begin
			cnt_ff <= cfg_ff.use_filt ? filt_cyc : '0;
		end else if (cnt_ff != '0) begin
			cnt_ff <= cnt_ff - 1'b1;
		end
	end

	// ------------------------------------------------------------------
	// Shadow copies of written device registers
	// ------------------------------------------------------------------
	// Whole-byte writes keep the other channel's bits intact
	always_ff @(posedge I_REF_CLK or posedge I_RST) begin
		if (I_RST) begin
			sh_pin_ff <= `DCIC_SHADOW_RST;
			sh_src_ff <= `DCIC_SHADOW_RST;
			sh_en_ff <= `DCIC_SHADOW_RST;
			sh_type_ff <= `DCIC_SHADOW_RST;
			sh_edge_ff <= `DCIC_SHADOW_RST;
			sh_clk_ff <= `DCIC_SHADOW_RST;
			sh_bg_ff <= `DCIC_SHADOW_RST;
			sh_ctl_ff[0] <= `DCIC_CTL_RST;
			sh_ctl_ff[1] <= `DCIC_CTL_RST;
		end else if (nxt_bus.wr) begin
			case (nxt_bus.addr)
				`DCIC_DEV_PIN4: sh_pin_ff <= nxt_bus.wdata;
				`DCIC_DEV_SRC: sh_src_ff <= nxt_bus.wdata;
				`DCIC_DEV_DET2: sh_en_ff <= nxt_bus.wdata;
				`DCIC_DEV_TYPE: sh_type_ff <= nxt_bus.wdata;
				`DCIC_DEV_EDGE: sh_edge_ff <= nxt_bus.wdata;
				`DCIC_DEV_CLK1: sh_clk_ff <= nxt_bus.wdata;
				`DCIC_DEV_BGR: sh_bg_ff <= nxt_bus.wdata;
				`DCIC_DEV_CTL1: sh_ctl_ff[0] <= nxt_bus.wdata;
				`DCIC_DEV_CTL2: sh_ctl_ff[1] <= nxt_bus.wdata;
				default: sh_pin_ff <= sh_pin_ff;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Read capture
	// ------------------------------------------------------------------
	// Comparator two keeps its result in a separate detect register
	always_ff @(posedge I_REF_CLK or posedge I_RST) begin
		if (I_RST) begin
			rd_sec_ff <= 1'b0;
			res_ff <= '0;
			dflag_ff <= '0;
			trim_cap_ff <= '0;
		end else if (state_ff == dcic_pkg::ST_IDLE) begin
			rd_sec_ff <= 1'b0;
		end else if (state_ff == dcic_pkg::ST_RD_CAP) begin
			rd_sec_ff <= 1'b1;
			if (op_ff == dcic_pkg::OP_TRIM_A ||
				op_ff == dcic_pkg::OP_TRIM_B) begin
				trim_cap_ff <= I_DEV_RDATA;
			end else if (rd_sec_ff) begin
				res_ff[1] <= I_DEV_RDATA[`DCIC_RES2_BIT];
			end else begin
				dflag_ff[ch_ff] <= I_DEV_RDATA[`DCIC_CTL_DFLAG_BIT];
				if (!ch_ff) begin
					res_ff[0] <= I_DEV_RDATA[`DCIC_CTL_RES_BIT];
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// Status flags
	// ------------------------------------------------------------------
	// Refusal and acceptance never coincide, so no set/clear conflict
	always_ff @(posedge I_REF_CLK or posedge I_RST) begin
		if (I_RST) begin
			err_ff <= 1'b0;
			done_ff <= 1'b0;
		end else begin
			if (cmd_wr && busy) begin
				err_ff <= 1'b1;
			end else if (cmd_go) begin
				err_ff <= 1'b0;
			end
			if (busy && nxt_state == dcic_pkg::ST_IDLE) begin
				done_ff <= 1'b1;
			end else if (cmd_go) begin
				done_ff <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// Software read port
	// ------------------------------------------------------------------
	// Data stand only in the cycle after the strobe, zero otherwise
	always_ff @(posedge I_REF_CLK or posedge I_RST) begin
		if (I_RST) begin
			sw_rdata_ff <= '0;
		end else if (I_SW_RD) begin
			case (I_SW_ADDR)
				`DCIC_SW_CFG: sw_rdata_ff <= {1'b0, cfg_ff};
				`DCIC_SW_STAT: sw_rdata_ff <= {1'b0, dflag_ff, res_ff,
					done_ff, err_ff, busy};
				`DCIC_SW_TRIM: sw_rdata_ff <= trim_cap_ff;
				default: sw_rdata_ff <= '0;
			endcase
		end else begin
			sw_rdata_ff <= '0;
		end
	end

	assign O_SW_RDATA = sw_rdata_ff;
	assign O_DEV_BUS = bus_ff;

endmodule : dcic_ctrl

// File: verif/dcic_ctrl_properties.sv
// Port checker of the comparator controller
`timescale 1ns/100ps
`include "dcic_regs.svh"
module dcic_ctrl_chk #(
	parameter int TD_EA_CYC = 20,
	parameter int LOCO_CYC = 2
) (
	input wire logic I_REF_CLK,
	input wire logic I_RST,
	input wire logic [3:0] I_SW_ADDR,
	input wire logic [7:0] I_SW_WDATA,
	input wire logic I_SW_WR,
	input wire logic I_SW_RD,
	input wire logic [7:0] O_SW_RDATA,
	input dcic_pkg::dcic_bus_s O_DEV_BUS,
	input wire logic [7:0] I_DEV_RDATA
);
	default clocking @(posedge I_REF_CLK); endclocking
	default disable iff (I_RST);
	logic wr;
	logic ctl;
	logic [7:0] a;
	logic [7:0] d;
	logic [15:0] ea_ff;
	logic osc_ff;
	logic [15:0] fw_ff;
	assign wr = O_DEV_BUS.wr;
	assign a = O_DEV_BUS.addr;
	assign d = O_DEV_BUS.wdata;
	assign ctl = wr && (a == `DCIC_DEV_CTL1 || a == `DCIC_DEV_CTL2);
	// Cycles since an enable write; saturates so it never wraps
	always_ff @(posedge I_REF_CLK or posedge I_RST) begin
		if (I_RST)
			ea_ff <= 16'h0000;
		else if (wr && a == `DCIC_DEV_DET2 && d[7:6] != 2'b00)
			ea_ff <= 16'h0000;
		else if (ea_ff != 16'hffff)
			ea_ff <= ea_ff + 16'h0001;
	end
	// Oscillator start seen on the device port
	always_ff @(posedge I_REF_CLK or posedge I_RST) begin
		if (I_RST)
			osc_ff <= 1'b0;
		else if (wr && a == `DCIC_DEV_CLK1 && !d[4])
			osc_ff <= 1'b1;
	end
	// Cycles since the last clock register write; saturates
	always_ff @(posedge I_REF_CLK or posedge I_RST) begin
		if (I_RST)
			fw_ff <= 16'h0000;
		else if (wr && a == `DCIC_DEV_CLK1)
			fw_ff <= 16'h0000;
		else if (fw_ff != 16'hffff)
			fw_ff <= fw_ff + 16'h0001;
	end
	AST_SW_RDATA: assert property (!$past(I_SW_RD) |-> O_SW_RDATA == 8'h00)
		else $error("read data outside its cycle");
	AST_BUS_EXCL: assert property (!(wr && O_DEV_BUS.rd))
		else $error("device read and write together");
	AST_BUS_IDLE: assert property (!(wr || O_DEV_BUS.rd) |-> a == 0 && d == 0)
		else $error("idle device bus not zero");
	AST_EA_WAIT: assert property (
		wr && a == `DCIC_DEV_TYPE |-> ea_ff >= TD_EA_CYC)
		else $error("type chosen before enable delay");
	AST_EDGE_DIR: assert property (
		wr && a == `DCIC_DEV_EDGE |-> ##[1:2] ctl)
		else $error("direction not written after edge mode");
	AST_OSC_IEN: assert property (
		ctl && d[0] |-> osc_ff && d[2])
		else $error("interrupt enabled before oscillator start");
	AST_CLR_IEN: assert property (
		ctl && !d[2] |-> !d[0] ##1 (wr && a == `DCIC_DEV_CLK1 && !d[4]))
		else $error("flag clear out of order");
	AST_TRIM: assert property (
		O_DEV_BUS.rd && a[7:1] == 7'h05 |-> ##[2:4]
		(wr && a == `DCIC_DEV_TRIM && d == $past(I_DEV_RDATA, 2)))
		else $error("trim copy wrong");
	AST_BG_OFF: assert property (
		wr && a == `DCIC_DEV_BGR && d[0] |->
		$past(wr && a == `DCIC_DEV_DET2 && !d[5]))
		else $error("bandgap off before detector shutdown");
	AST_FILT_WAIT: assert property (
		ctl && d[0] |-> d[1] || fw_ff >= ((4 * LOCO_CYC) << d[5:4]))
		else $error("interrupt enabled before filter settled");
endmodule : dcic_ctrl_chk

bind dcic_ctrl dcic_ctrl_chk #(.TD_EA_CYC(TD_EA_CYC),
	.LOCO_CYC(LOCO_CYC)) u_chk (
	.I_REF_CLK(I_REF_CLK), .I_RST(I_RST), .I_SW_ADDR(I_SW_ADDR),
	.I_SW_WDATA(I_SW_WDATA), .I_SW_WR(I_SW_WR), .I_SW_RD(I_SW_RD),
	.O_SW_RDATA(O_SW_RDATA), .O_DEV_BUS(O_DEV_BUS),
	.I_DEV_RDATA(I_DEV_RDATA));

// File: verif/dcic_dev_model.sv
// Behavioural model of the dual comparator device registers
`timescale 1ns/100ps
module dcic_dev_model #(
	parameter logic [7:0] FACT_A = 8'h5a,
	parameter logic [7:0] FACT_B = 8'h3c,
	parameter int TD = 20
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input dcic_pkg::dcic_bus_s i_bus,
	input wire logic [1:0] i_lvl,
	output logic [7:0] o_rdata
);
	logic [7:0] regs_ff [0:12];
	logic [1:0] lvl_ff;
	logic [1:0] res;
	logic [7:0] rd;
	logic [7:0] ea_ff [2];
	logic [1:0] act;
	logic [1:0] smp_ff;
	logic [1:0] flt_ff;
	logic [1:0] eff;
	logic [1:0] ir_ff;
	logic [1:0] nmi_ff;
	// A comparator stays inactive until its enable delay has run out
	assign act[0] = regs_ff[3][6] && ea_ff[0] == 8'(TD);
	assign act[1] = regs_ff[3][7] && ea_ff[1] == 8'(TD);
	// A disabled or settling comparator reads as at-or-above
	assign res = i_lvl | ~act;
	// Filtered value, unless that channel's filter is disabled
	assign eff[0] = regs_ff[4][1] ? res[0] : flt_ff[0];
	assign eff[1] = regs_ff[5][1] ? res[1] : flt_ff[1];
	// Result bits are live, not stored
	always_comb begin
		rd = regs_ff[i_bus.addr[3:0]];
		if (i_bus.addr == 8'h04)
			rd[3] = res[0];
		if (i_bus.addr == 8'h02)
			rd[3] = res[1];
	end
	// Register file; factory trims are read-only
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			for (int i = 0; i < 13; i++)
				regs_ff[i] <= 8'h00;
			regs_ff[9] <= FACT_A;
			regs_ff[10] <= FACT_A;
			regs_ff[11] <= FACT_B;
			lvl_ff <= 2'b00;
			ea_ff[0] <= 8'h00;
			ea_ff[1] <= 8'h00;
			smp_ff <= 2'b11;
			flt_ff <= 2'b11;
			ir_ff <= 2'b00;
			nmi_ff <= 2'b00;
		end else begin
			lvl_ff <= eff;
			smp_ff <= res;
			if (i_bus.wr && i_bus.addr[3:1] != 3'b101)
				regs_ff[i_bus.addr[3:0]] <= i_bus.wdata;
			for (int c = 0; c < 2; c++) begin
				if (!regs_ff[3][6 + c])
					ea_ff[c] <= 8'h00;
				else if (ea_ff[c] != 8'(TD))
					ea_ff[c] <= ea_ff[c] + 8'h01;
				// A change is taken once two samples in a row agree
				if (res[c] == smp_ff[c])
					flt_ff[c] <= res[c];
				if (i_bus.wr && i_bus.addr == 8'h04 + c)
					regs_ff[4 + c][2] <= regs_ff[4 + c][2] & i_bus.wdata[2];
				if (eff[c] != lvl_ff[c] && regs_ff[4 + c][0] &&
					(regs_ff[7][c + 1] || eff[c] == regs_ff[4 + c][7])) begin
					regs_ff[4 + c][2] <= 1'b1;
					// Type bit picks the maskable request or the NMI
					if (regs_ff[6][c + 1])
						ir_ff[c] <= 1'b1;
					else
						nmi_ff[c] <= 1'b1;
				end
			end
		end
	end
	// Answer one cycle after a read; otherwise keep toggling
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst)
			o_rdata <= 8'h00;
		else if (i_bus.rd)
			o_rdata <= rd;
		else
			o_rdata <= ~o_rdata;
	end
endmodule : dcic_dev_model

// File: verif/dcic_ctrl_tb.sv
// Testbench of the dual comparator controller
`timescale 1ns/100ps
`include "dcic_regs.svh"
module dcic_ctrl_tb;
	localparam logic [7:0] FA = 8'h5a;
	localparam logic [7:0] FB = 8'h3c;
	logic clk;
	logic rst;
	logic [3:0] addr;
	logic [7:0] wdata;
	logic wr;
	logic rd;
	logic [7:0] rdata;
	logic [7:0] dev_rdata;
	logic [1:0] lvl;
	logic [7:0] v;
	dcic_pkg::dcic_bus_s bus;
	int miscompares;
	int total_checks;
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	dcic_ctrl #(.TD_EA_CYC(20), .LOCO_CYC(2)) u_dut (.I_REF_CLK(clk),
		.I_RST(rst), .I_SW_ADDR(addr), .I_SW_WDATA(wdata), .I_SW_WR(wr),
		.I_SW_RD(rd), .O_SW_RDATA(rdata), .O_DEV_BUS(bus),
		.I_DEV_RDATA(dev_rdata));
	dcic_dev_model #(.FACT_A(FA), .FACT_B(FB), .TD(20)) u_dev (.i_clk(clk),
		.i_rst(rst), .i_bus(bus), .i_lvl(lvl), .o_rdata(dev_rdata));
	task automatic summarize();
		if (miscompares == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : summarize
	task automatic chk(input string n, input logic [7:0] e,
		input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// One-cycle strobes with a gap, so no signal is set twice at an edge
	task automatic sw_wr(input logic [3:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask : sw_wr
	task automatic sw_rd(input logic [3:0] a, output logic [7:0] d);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
		@(posedge clk);
	endtask : sw_rd
	// Poll busy under a bound; a hang ends the run as a failure
	task automatic wait_idle();
		for (int i = 0; i < 300; i++) begin
			sw_rd(`DCIC_SW_STAT, v);
			if (v[0] === 1'b0)
				return;
		end
		miscompares++;
		summarize();
	endtask : wait_idle
	task automatic cmd(input logic [7:0] c);
		sw_wr(`DCIC_SW_CMD, c);
		wait_idle();
	endtask : cmd
	initial begin
		miscompares = 0;
		total_checks = 0;
		rst = 1'b1;
		addr = 4'h0;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		lvl = 2'b00;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk("trim", FA, u_dev.regs_ff[9]);
		// Comparator one: filtered, maskable, one edge
		sw_wr(`DCIC_SW_CFG, 8'h66);
		cmd(8'h01);
		chk("ctl1", 8'h91, u_dev.regs_ff[4] & 8'hf7);
		chk("pin", 8'h10, u_dev.regs_ff[0] & 8'h10);
		chk("src1", 8'h20, u_dev.regs_ff[1] & 8'h21);
		chk("type1", 8'h02, u_dev.regs_ff[6] & 8'h06);
		chk("edge1", 8'h00, u_dev.regs_ff[7] & 8'h06);
		chk("osc", 8'h00, u_dev.regs_ff[8] & 8'h10);
		chk("stat", 8'h04, v & 8'h07);
		// Comparator two with a command refused while busy
		sw_wr(`DCIC_SW_CFG, 8'h11);
		sw_wr(`DCIC_SW_CMD, 8'h09);
		sw_wr(`DCIC_SW_CMD, 8'h07);
		// Configuration written while busy must be ignored
		sw_wr(`DCIC_SW_CFG, 8'h7f);
		sw_rd(`DCIC_SW_STAT, v);
		chk("busy err", 8'h03, v & 8'h03);
		wait_idle();
		chk("ctl2", 8'h03, u_dev.regs_ff[5] & 8'hf7);
		chk("type2", 8'h02, u_dev.regs_ff[6] & 8'h06);
		chk("edge2", 8'h04, u_dev.regs_ff[7] & 8'h06);
		chk("src2", 8'h61, u_dev.regs_ff[1] & 8'h61);
		chk("det2", 8'hc0, u_dev.regs_ff[3] & 8'hc0);
		sw_rd(`DCIC_SW_CFG, v);
		chk("cfg", 8'h11, v);
		// Both inputs cross, then both results and flags are read
		lvl <= 2'b11;
		repeat (3) @(posedge clk);
		cmd(8'h03);
		cmd(8'h0b);
		chk("stat", 8'h7c, v & 8'h7f);
		chk("irq", 8'h09, {4'h0, u_dev.nmi_ff, u_dev.ir_ff});
		for (int i = 0; i < 2; i++) begin
			cmd(i ? 8'h04 : 8'h05);
			chk("trim", i ? FA : FB, u_dev.regs_ff[9]);
			sw_rd(`DCIC_SW_TRIM, v);
			chk("trim cap", i ? FA : FB, v);
		end
		cmd(8'h06);
		chk("bgr", 8'h01, u_dev.regs_ff[12]);
		chk("det2", 8'hc0, u_dev.regs_ff[3] & 8'he0);
		cmd(8'h07);
		chk("bgr", 8'h00, u_dev.regs_ff[12]);
		// Monitor only: comparator one now below its reference
		lvl <= 2'b10;
		cmd(8'h02);
		chk("mon", 8'h74, v & 8'h7f);
		sw_rd(4'hf, v);
		chk("unmapped", 8'h00, v);
		summarize();
	end
endmodule : dcic_ctrl_tb
